// ### src/sacoc_top.sv
`timescale 1ns/1ps
// Behaviour
// - The fixed 3.3 V converter is enabled automatically at power-up without any host command.
// - The host can switch the adjustable converter off by clearing its enable bit.
// - The adjustable converter is enabled only while the filtered supply is good.
// - The adjustable converter good flag is readable by the host in the status register.
// - The 20 V regulator enable defaults to on and the host may clear it.
// - The 20 V regulator is enabled only while the filtered supply is good.
// - The 20 V regulator good flag is readable by the host in the status register.
// - The main 16 MHz clock source is chosen between crystal and external clock by a select input.
// - The clock output is 8 MHz, doubled to 16 MHz by a select bit, and switched off by an enable bit.
// - After power-up in Stand-By the clock output carries an internal 4 MHz clock.
// - On entering Normal the clock output switches to the crystal 8 or 16 MHz clock.
// - Leaving Normal for Stand-By without an oscillator fault keeps the 8 or 16 MHz output.
// - Stand-By entered from Normal due to an oscillator fault falls back to 4 MHz.
// - After Stand-By from Normal the converter and regulator stay on only if neither caused it.
module sacoc_top (
	// Clock and reset
	input  wire logic                         I_CLOCK,
	input  wire logic                         I_RESET,
	// Clock source
	input  wire logic                         I_CLOCK_SOURCE_SELECT,
	output logic                              O_USE_EXTERNAL_CLOCK,
	// Power state inputs
	input  wire logic                         I_FIXED_CONVERTER_UP,
	input  wire logic                         I_REQUEST_NORMAL,
	input  wire logic                         I_REQUEST_SLEEP,
	input  wire logic                         I_WAKE,
	input  wire logic                         I_OSC_FAULT,
	input  wire logic                         I_THERMAL_SHUTDOWN,
	// Supply supervisors
	input  wire sacoc_pkg::sacoc_supply_t     I_SUPPLY,
	// Supply enables
	output logic                              O_FIXED_CONVERTER_EN,
	output logic                              O_ADJUSTABLE_CONVERTER_EN,
	output logic                              O_HV_REG_EN,
	// Host clock and power state
	output logic                              O_HOST_CLOCK_OUT,
	output sacoc_pkg::sacoc_power_state_t     O_STATE,
	// Register port
	input  wire logic [3:0]                   I_ADDR,
	input  wire logic [7:0]                   I_WDATA,
	input  wire logic                         I_WRITE,
	input  wire logic                         I_READ,
	output logic [7:0]                        O_RDATA,
	output logic                              O_IRQ
);
	import sacoc_pkg::*;

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	sacoc_power_state_t state_reg, state_next;
	logic               osc_fault_entry_reg, osc_fault_entry_next;
	logic               supply_fault_entry_reg, supply_fault_entry_next;
	logic               from_normal_reg, from_normal_next;
	sacoc_supply_t      supply_prev_reg;

	always_comb begin
		state_next              = state_reg;
		osc_fault_entry_next    = osc_fault_entry_reg;
		supply_fault_entry_next = supply_fault_entry_reg;
		from_normal_next        = from_normal_reg;
		case (state_reg)
			SACOC_RESET: begin
				if (!I_THERMAL_SHUTDOWN) begin
					state_next = SACOC_STARTUP;
				end
			end
			SACOC_STARTUP: begin
				if (I_THERMAL_SHUTDOWN) begin
					state_next = SACOC_RESET;
				end else if (I_FIXED_CONVERTER_UP) begin
					state_next              = SACOC_STANDBY;
					from_normal_next        = 1'b0;
					osc_fault_entry_next    = 1'b0;
					supply_fault_entry_next = 1'b0;
				end
			end
			SACOC_STANDBY: begin
				if (I_THERMAL_SHUTDOWN) begin
					state_next = SACOC_RESET;
				end else if (I_REQUEST_SLEEP) begin
					state_next = SACOC_SLEEP;
				end else if (I_REQUEST_NORMAL && !I_OSC_FAULT && I_SUPPLY.filtered_supply_good) begin
					state_next = SACOC_NORMAL;
				end
			end
			SACOC_NORMAL: begin
				if (I_THERMAL_SHUTDOWN) begin
					state_next = SACOC_RESET;
				end else if (I_REQUEST_SLEEP) begin
					state_next = SACOC_SLEEP;
				end else if (!I_REQUEST_NORMAL || I_OSC_FAULT || !I_SUPPLY.filtered_supply_good
				             || (supply_prev_reg.adj_conv_good && !I_SUPPLY.adj_conv_good)
				             || (supply_prev_reg.hv_reg_good && !I_SUPPLY.hv_reg_good)) begin
					state_next              = SACOC_STANDBY;
					from_normal_next        = 1'b1;
					osc_fault_entry_next    = I_OSC_FAULT;
					supply_fault_entry_next = (supply_prev_reg.adj_conv_good && !I_SUPPLY.adj_conv_good)
					                          || (supply_prev_reg.hv_reg_good && !I_SUPPLY.hv_reg_good);
				end
			end
			SACOC_SLEEP: begin
				if (I_WAKE) begin
					state_next = SACOC_STARTUP;
				end
			end
			default: begin
				state_next = SACOC_RESET;
			end
		endcase
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			state_reg              <= SACOC_RESET;
			osc_fault_entry_reg    <= 1'b0;
			supply_fault_entry_reg <= 1'b0;
			from_normal_reg        <= 1'b0;
			supply_prev_reg        <= '0;
		end else begin
			state_reg              <= state_next;
			osc_fault_entry_reg    <= osc_fault_entry_next;
			supply_fault_entry_reg <= supply_fault_entry_next;
			from_normal_reg        <= from_normal_next;
			supply_prev_reg        <= I_SUPPLY;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	sacoc_control_t           control_reg, control_next;
	logic [IRQ_WIDTH-1:0]     irq_status_reg, irq_status_next;
	logic [IRQ_WIDTH-1:0]     irq_mask_reg, irq_mask_next;
	logic [7:0]               rdata_reg, rdata_next;
	logic [IRQ_WIDTH-1:0]     events;

	assign events[IRQ_FILT_CHANGE]  = supply_prev_reg.filtered_supply_good != I_SUPPLY.filtered_supply_good;
	assign events[IRQ_ADJ_CHANGE]   = supply_prev_reg.adj_conv_good != I_SUPPLY.adj_conv_good;
	assign events[IRQ_HV_CHANGE]    = supply_prev_reg.hv_reg_good != I_SUPPLY.hv_reg_good;
	assign events[IRQ_STATE_CHANGE] = state_next != state_reg;

	always_comb begin
		control_next    = control_reg;
		irq_mask_next   = irq_mask_reg;
		irq_status_next = irq_status_reg;
		rdata_next      = 8'h00;
		if (I_WRITE) begin
			if (I_ADDR == ADDR_CONTROL) begin
				control_next = sacoc_control_t'(I_WDATA[3:0]);
			end else if (I_ADDR == ADDR_IRQ_MASK) begin
				irq_mask_next = I_WDATA[IRQ_WIDTH-1:0];
			end
		end
		if (I_READ) begin
			if (I_ADDR == ADDR_CONTROL) begin
				rdata_next = {4'h0, control_reg};
			end else if (I_ADDR == ADDR_STATUS) begin
				rdata_next = {2'h0, state_reg, I_SUPPLY};
			end else if (I_ADDR == ADDR_IRQ_STATUS) begin
				rdata_next      = {4'h0, irq_status_reg};
				irq_status_next = '0;
			end else if (I_ADDR == ADDR_IRQ_MASK) begin
				rdata_next = {4'h0, irq_mask_reg};
			end
		end
		// A new event wins over the clear-on-read in the same cycle.
		irq_status_next = irq_status_next | events;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			control_reg    <= sacoc_control_t'(CONTROL_RESET);
			irq_status_reg <= '0;
			irq_mask_reg   <= '0;
			rdata_reg      <= 8'h00;
		end else begin
			control_reg    <= control_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg   <= irq_mask_next;
			rdata_reg      <= rdata_next;
		end
	end

	assign O_RDATA = rdata_reg;
	assign O_IRQ   = |(irq_status_reg & irq_mask_reg);

	// ----------------------------------------------------------------
	// Supply enables
	// ----------------------------------------------------------------
	logic supplies_allowed;
	logic fixed_en_reg, adj_en_reg, hv_en_reg;

	// Supplies run in Normal, in Stand-By reached from Start-Up, and in Stand-By reached from Normal unless a supply fault caused it.
	assign supplies_allowed = (state_reg == SACOC_NORMAL)
	                          || (state_reg == SACOC_STANDBY && from_normal_reg && !supply_fault_entry_reg)
	                          || (state_reg == SACOC_STANDBY && !from_normal_reg);

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			fixed_en_reg <= 1'b0;
			adj_en_reg   <= 1'b0;
			hv_en_reg    <= 1'b0;
		end else begin
			fixed_en_reg <= state_next == SACOC_STARTUP || state_next == SACOC_STANDBY
			                || state_next == SACOC_NORMAL;
			adj_en_reg   <= supplies_allowed && control_reg.adj_conv_enable
			                && I_SUPPLY.filtered_supply_good;
			hv_en_reg    <= supplies_allowed && control_reg.hv_reg_enable
			                && I_SUPPLY.filtered_supply_good;
		end
	end

	assign O_FIXED_CONVERTER_EN      = fixed_en_reg;
	assign O_ADJUSTABLE_CONVERTER_EN = adj_en_reg;
	assign O_HV_REG_EN               = hv_en_reg;
	assign O_USE_EXTERNAL_CLOCK      = I_CLOCK_SOURCE_SELECT;
	assign O_STATE                   = state_reg;

	// ----------------------------------------------------------------
	// Host clock output
	// ----------------------------------------------------------------
	// Mode changes are taken only while the output is low, so no runt pulse appears.
	typedef enum logic [1:0] {
		SACOC_CLK_OFF,
		SACOC_CLK_SLOW,
		SACOC_CLK_8,
		SACOC_CLK_16
	} sacoc_clk_mode_t;

	sacoc_clk_mode_t want_mode, mode_reg, mode_next;
	logic            clk_out_reg, clk_out_next;
	logic [1:0]      div_reg, div_next;

	always_comb begin
		want_mode = SACOC_CLK_OFF;
		if (state_reg == SACOC_STANDBY && (!from_normal_reg || osc_fault_entry_reg)) begin
			want_mode = SACOC_CLK_SLOW;
		end else if ((state_reg == SACOC_NORMAL || state_reg == SACOC_STANDBY) && control_reg.clk_out_enable) begin
			want_mode = control_reg.clk_out_double ? SACOC_CLK_16 : SACOC_CLK_8;
		end
	end

	always_comb begin
		mode_next    = mode_reg;
		clk_out_next = clk_out_reg;
		div_next     = div_reg;
		if (!clk_out_reg) begin
			mode_next = want_mode;
		end
		case (mode_reg)
			SACOC_CLK_OFF: begin
				clk_out_next = 1'b0;
				div_next     = 2'h0;
			end
			SACOC_CLK_SLOW: begin
				if (div_reg == SLOW_HALF_LAST) begin
					div_next     = 2'h0;
					clk_out_next = !clk_out_reg;
				end else begin
					div_next = div_reg + 2'h1;
				end
			end
			SACOC_CLK_8: begin
				clk_out_next = !clk_out_reg;
			end
			SACOC_CLK_16: begin
				clk_out_next = 1'b0;
			end
			default: begin
				clk_out_next = 1'b0;
			end
		endcase
		// A switch starts the new mode from low, so the old mode never adds a trailing pulse.
		if (!clk_out_reg && want_mode != mode_reg) begin
			clk_out_next = 1'b0;
			div_next     = 2'h0;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			mode_reg    <= SACOC_CLK_OFF;
			clk_out_reg <= 1'b0;
			div_reg     <= 2'h0;
		end else begin
			mode_reg    <= mode_next;
			clk_out_reg <= clk_out_next;
			div_reg     <= div_next;
		end
	end

	// Full rate passes the main clock itself. The select changes on the falling edge, while the main
	// clock is low and the divided output is low too, so neither switching direction can cut a pulse.
	logic full_rate_reg;

	always_ff @(negedge I_CLOCK) begin
		if (I_RESET) begin
			full_rate_reg <= 1'b0;
		end else begin
			full_rate_reg <= mode_reg == SACOC_CLK_16;
		end
	end

	assign O_HOST_CLOCK_OUT = full_rate_reg ? I_CLOCK : clk_out_reg;

endmodule : sacoc_top

// ### src/sacoc_pkg.sv
package sacoc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS     = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK   = 4'h3;

	// Control register bit positions.
	localparam int CTL_ADJ_CONV_ENABLE = 0;
	localparam int CTL_HV_REG_ENABLE   = 1;
	localparam int CTL_CLK_OUT_DOUBLE  = 2;
	localparam int CTL_CLK_OUT_ENABLE  = 3;

	// Control reset value: adjustable converter on, regulator on, 8 MHz, output on.
	localparam logic [3:0] CONTROL_RESET = 4'hB;

	// Interrupt bit positions.
	localparam int IRQ_FILT_CHANGE  = 0;
	localparam int IRQ_ADJ_CHANGE   = 1;
	localparam int IRQ_HV_CHANGE    = 2;
	localparam int IRQ_STATE_CHANGE = 3;
	localparam int IRQ_WIDTH        = 4;

	// ----------------------------------------------------------------
	// Clock figures
	// ----------------------------------------------------------------
	localparam int MAIN_CLOCK_MHZ = 16;
	localparam int SLOW_CLOCK_MHZ = 4;
	// Half periods of the output clock, in main clock cycles.
	localparam int SLOW_HALF_CYCLES = MAIN_CLOCK_MHZ / (2 * SLOW_CLOCK_MHZ);
	localparam logic [1:0] SLOW_HALF_LAST = 2'(SLOW_HALF_CYCLES - 1);

	typedef enum logic [2:0] {
		SACOC_RESET,
		SACOC_STARTUP,
		SACOC_STANDBY,
		SACOC_NORMAL,
		SACOC_SLEEP
	} sacoc_power_state_t;

	// The first field is the most significant, so the order runs from bit 3 down to bit 0.
	typedef struct packed {
		logic clk_out_enable;
		logic clk_out_double;
		logic hv_reg_enable;
		logic adj_conv_enable;
	} sacoc_control_t;

	typedef struct packed {
		logic filtered_supply_good;
		logic adj_conv_good;
		logic hv_reg_good;
	} sacoc_supply_t;

endpackage : sacoc_pkg

// ### dv/sacoc_asserts.sv
`timescale 1ns/1ps
module sacoc_asserts
	import sacoc_pkg::*;
(
	// Clock, reset and state inputs
	input wire logic               I_CLOCK,
	input wire logic               I_RESET,
	input wire logic               I_CLOCK_SOURCE_SELECT,
	input wire logic               I_OSC_FAULT,
	input wire logic               I_THERMAL_SHUTDOWN,
	input wire logic               I_REQUEST_SLEEP,
	input wire sacoc_supply_t      I_SUPPLY,
	// Outputs and read port watched
	input wire logic               O_USE_EXTERNAL_CLOCK,
	input wire logic               O_FIXED_CONVERTER_EN,
	input wire logic               O_ADJUSTABLE_CONVERTER_EN,
	input wire logic               O_HV_REG_EN,
	input wire logic               O_HOST_CLOCK_OUT,
	input wire sacoc_power_state_t O_STATE,
	input wire logic [3:0]         I_ADDR,
	input wire logic               I_READ,
	input wire logic [7:0]         O_RDATA,
	input wire logic               O_IRQ
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	a_src_follows: assert property (O_USE_EXTERNAL_CLOCK == I_CLOCK_SOURCE_SELECT) else $error("source select");
	a_fixed_on: assert property ((O_STATE == SACOC_STANDBY) [*2] |-> O_FIXED_CONVERTER_EN) else $error("fixed off");
	a_adj_needs_filt: assert property (!I_SUPPLY.filtered_supply_good |=> !O_ADJUSTABLE_CONVERTER_EN) else $error("adj on");
	a_hv_needs_filt: assert property (!I_SUPPLY.filtered_supply_good |=> !O_HV_REG_EN) else $error("hv on");
	a_sleep_off: assert property ((O_STATE == SACOC_SLEEP) [*2] |-> !O_ADJUSTABLE_CONVERTER_EN && !O_HV_REG_EN)
		else $error("supply on in sleep");
	a_startup_low: assert property ((O_STATE inside {SACOC_RESET, SACOC_STARTUP, SACOC_SLEEP}) [*3] |-> !O_HOST_CLOCK_OUT)
		else $error("clock out active");
	a_osc_fallback: assert property (O_STATE == SACOC_NORMAL && I_OSC_FAULT && !I_THERMAL_SHUTDOWN && !I_REQUEST_SLEEP
		|=> O_STATE == SACOC_STANDBY) else $error("no fallback");
	a_rdata_idle: assert property (!$past(I_READ) |-> O_RDATA == 8'h00) else $error("read data stands");
	a_status_read: assert property (I_READ && I_ADDR == ADDR_STATUS |=> O_RDATA == {2'b00, $past(O_STATE), $past(I_SUPPLY)})
		else $error("status value");
	c_normal: cover property (O_STATE == SACOC_NORMAL);
	c_osc: cover property (O_STATE == SACOC_NORMAL && I_OSC_FAULT);
	c_irq: cover property (O_IRQ);
endmodule : sacoc_asserts
bind sacoc_top sacoc_asserts sacoc_asserts_i (.*);

// ### dv/sacoc_host_model.sv
`timescale 1ns/1ps
// Host side: tallies rising edges of the clock it receives, so the bench can measure its rate.
module sacoc_host_model (
	// Clock from the device
	input  wire logic        i_host_clock,
	// Edge tally
	output logic      [15:0] o_edges
);
	initial o_edges = 16'h0000;
	always @(posedge i_host_clock) begin
		o_edges <= o_edges + 16'h0001;
	end
endmodule : sacoc_host_model

// ### dv/sacoc_top_bench.sv
`timescale 1ns/1ps
module sacoc_top_bench;
	import sacoc_pkg::*;
	logic clk, rst, src, fup, rqn, rqs, wake, osc, tsd, wr, rdn, ext, fen, aen, hen, hclk, irq;
	sacoc_supply_t sup;
	sacoc_power_state_t st;
	logic [3:0] addr;
	logic [7:0] wd, rd, got;
	logic [15:0] edges;
	int fail_count, checked, cyc;
	sacoc_top sacoc_top_i (.I_CLOCK(clk), .I_RESET(rst), .I_CLOCK_SOURCE_SELECT(src), .O_USE_EXTERNAL_CLOCK(ext),
		.I_FIXED_CONVERTER_UP(fup), .I_REQUEST_NORMAL(rqn), .I_REQUEST_SLEEP(rqs), .I_WAKE(wake), .I_OSC_FAULT(osc),
		.I_THERMAL_SHUTDOWN(tsd), .I_SUPPLY(sup), .O_FIXED_CONVERTER_EN(fen), .O_ADJUSTABLE_CONVERTER_EN(aen),
		.O_HV_REG_EN(hen), .O_HOST_CLOCK_OUT(hclk), .O_STATE(st), .I_ADDR(addr), .I_WDATA(wd), .I_WRITE(wr),
		.I_READ(rdn), .O_RDATA(rd), .O_IRQ(irq));
	sacoc_host_model sacoc_host_model_i (.i_host_clock(hclk), .o_edges(edges));
	task automatic stop_test();
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic step(int n);
		repeat (n) @(posedge clk);
	endtask : step
	task automatic wr_reg(logic [3:0] a, logic [7:0] d);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [3:0] a, logic [7:0] e, string n);
		addr <= a;
		rdn <= 1'b1;
		@(posedge clk);
		rdn <= 1'b0;
		@(negedge clk);
		cmp(n, 16'(e), 16'(rd));
		@(posedge clk);
	endtask : rd_reg
	// Edges in a window of whole cycles, opened and closed on falling edges to stay clear of the launch.
	task automatic count(logic [15:0] e, string n);
		logic [15:0] e0;
		@(negedge clk);
		e0 = edges;
		repeat (40) @(negedge clk);
		cmp(n, e, edges - e0);
		@(posedge clk);
	endtask : count
	task automatic wait_st(sacoc_power_state_t s);
		int k;
		for (k = 0; k < 60 && st !== s; k++) @(posedge clk);
		cmp("state", 16'(s), 16'(st));
		step(8);
	endtask : wait_st
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		{rst, src, fup, rqn, rqs, wake, osc, tsd, wr, rdn} = 10'b10_0000_0000;
		sup = 3'b000;
		addr = 4'h0;
		wd = 8'h00;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_st(SACOC_STARTUP);
		sup <= 3'b111;
		fup <= 1'b1;
		src <= 1'b1;
		wait_st(SACOC_STANDBY);
		cmp("ext", 16'h0001, 16'(ext));
		cmp("fix", 16'h0007, 16'({fen, aen, hen}));
		count(16'h000A, "clk4");
		rd_reg(ADDR_CONTROL, 8'(CONTROL_RESET), "ctl");
		rd_reg(ADDR_STATUS, {2'b00, SACOC_STANDBY, 3'b111}, "sts");
		rd_reg(4'hF, 8'h00, "unmapped");
		rd_reg(ADDR_IRQ_MASK, 8'h00, "mask");
		rd_reg(ADDR_IRQ_STATUS, 8'h0F, "irq0");
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		sup <= 3'b011;
		step(3);
		cmp("filt", 16'h0004, 16'({irq, aen, hen}));
		rd_reg(ADDR_IRQ_STATUS, 8'h01, "irq1");
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		sup <= 3'b111;
		step(3);
		cmp("masked", 16'h0003, 16'({irq, aen, hen}));
		rqn <= 1'b1;
		wait_st(SACOC_NORMAL);
		count(16'h0014, "clk8");
		wr_reg(ADDR_CONTROL, 8'h0F);
		step(8);
		count(16'h0028, "clk16");
		wr_reg(ADDR_CONTROL, 8'h02);
		step(8);
		cmp("off", 16'h0001, 16'({hclk, aen, hen}));
		count(16'h0000, "clkoff");
		wr_reg(ADDR_CONTROL, 8'h0B);
		rqn <= 1'b0;
		wait_st(SACOC_STANDBY);
		count(16'h0014, "keep8");
		rqn <= 1'b1;
		wait_st(SACOC_NORMAL);
		osc <= 1'b1;
		wait_st(SACOC_STANDBY);
		count(16'h000A, "fall4");
		osc <= 1'b0;
		wait_st(SACOC_NORMAL);
		sup <= 3'b101;
		rqn <= 1'b0;
		wait_st(SACOC_STANDBY);
		cmp("adjfault", 16'h0000, 16'({aen, hen}));
		rqs <= 1'b1;
		wait_st(SACOC_SLEEP);
		cmp("sleepfix", 16'h0000, 16'({fen, aen, hen}));
		count(16'h0000, "sleep");
		rqs <= 1'b0;
		wake <= 1'b1;
		wait_st(SACOC_STANDBY);
		wake <= 1'b0;
		tsd <= 1'b1;
		wait_st(SACOC_RESET);
		tsd <= 1'b0;
		wait_st(SACOC_STANDBY);
		stop_test();
	end
endmodule : sacoc_top_bench
